/* usb_event_cfg.svh */
// Register offsets, field positions, reset values and timing counts of the USB event unit.
`ifndef USB_EVENT_CFG_SVH
`define USB_EVENT_CFG_SVH

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define EV_FLAGS_OFS 12'h000
`define EV_ENABLES_OFS 12'h004
`define FAULT_STATUS_OFS 12'h008
`define FAULT_ENABLES_OFS 12'h00C
`define XFER_STATUS_OFS 12'h010

// ---------------------------------------------------------------------------
// Event bit positions
// ---------------------------------------------------------------------------
`define EV_BIT_STALL 7
`define EV_BIT_UNUSED 6
`define EV_BIT_WAKEUP 5
`define EV_BIT_IDLE 4
`define EV_BIT_XFER 3
`define EV_BIT_SOF 2
`define EV_BIT_FAULT 1
`define EV_BIT_BUSRST 0

// ---------------------------------------------------------------------------
// Reset values and masks
// ---------------------------------------------------------------------------
`define EV_FLAGS_RST 8'h00
`define EV_ENABLES_RST 8'h00
`define FAULT_RST 8'h00
`define EV_IMPL_MASK 8'hBF
`define FAULT_IMPL_MASK 8'hBF

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define CLK_HZ 40000000
`define WAKEUP_DELAY_NS 2500
`define BUSRST_HOLD_NS 2500
`define IDLE_TIME_US 3000
`define WAKEUP_CYCLES ((`WAKEUP_DELAY_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define BUSRST_CYCLES ((`BUSRST_HOLD_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define IDLE_CYCLES (`IDLE_TIME_US * (`CLK_HZ / 1000000))

`endif

/* usb_event_pkg.sv */
// Types shared by the USB event unit.
package usb_event_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_t;
endpackage : usb_event_pkg

/* hold_timer.sv */
// Counts how long a level has held and pulses once when it reaches the limit.
`timescale 1ns/100ps
module hold_timer #(
  parameter int unsigned LIMIT = 100,
  parameter int unsigned W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic level,
  output logic fire
);
  logic [W-1:0] count_reg;
  logic done_reg;

  // Counter restarts whenever the level drops; fires once per held stretch.
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= '0;
      done_reg <= 1'b0;
      fire <= 1'b0;
    end else if (ce) begin
      fire <= 1'b0;
      if (!level) begin
        count_reg <= '0;
        done_reg <= 1'b0;
      end else if (!done_reg) begin
        if (count_reg == W'(LIMIT - 1)) begin
          fire <= 1'b1;
          done_reg <= 1'b1;
        end else begin
          count_reg <= count_reg + W'(1);
        end
      end
    end
  end
endmodule : hold_timer

/* sync2.sv */
// Two flip-flop synchroniser for a group of pin levels.
`timescale 1ns/100ps
module sync2 #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      q <= '0;
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : sync2

/* usb_event_interrupt_unit.sv */
// USB device event flags, enables and interrupt request behind an AXI4-Lite slave.
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "usb_event_cfg.svh"

module usb_event_interrupt_unit #(
  parameter int unsigned IDLE_CYCLES = `IDLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // AXI4-Lite slave.
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Event strobes from the serial interface engine, same clock.
  input wire logic stall_sent,
  input wire logic xfer_done,
  input wire logic sof_token,
  input wire logic [7:0] fault_events,
  input wire logic clocks_restarted,
  input wire logic [7:0] xfer_status_in,
  input wire logic xfer_queue_valid,
  output logic xfer_queue_pop,
  // Bus line levels, asynchronous to clk.
  input wire logic bus_idle_pin,
  input wire logic bus_kstate_pin,
  input wire logic bus_reset_pin,
  output logic irq
);

  // -------------------------------------------------------------------------
  // Storage
  // -------------------------------------------------------------------------
  // Register images and the wires that join the stages below.
  usb_event_pkg::byte_t usb_event_flags_reg;
  usb_event_pkg::byte_t usb_event_enables_reg;
  usb_event_pkg::byte_t fault_status_register_reg;
  usb_event_pkg::byte_t fault_enables_reg;
  usb_event_pkg::byte_t xfer_status_reg;
  usb_event_pkg::byte_t set_vec;
  usb_event_pkg::byte_t ev_clear;
  usb_event_pkg::byte_t fault_clear;
  usb_event_pkg::wr_state_t wr_state_reg;
  logic [11:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic wr_fire;
  logic idle_s;
  logic kstate_s;
  logic busrst_s;
  logic idle_fire;
  logic busrst_fire;
  logic wakeup_fire;
  logic wake_arm_reg;
  logic fault_any;

  // -------------------------------------------------------------------------
  // Pin synchronisers and timers
  // -------------------------------------------------------------------------
  // Bus levels come from the transceiver and must be synchronised first.
  // Nothing but the second stage ever reads the possibly metastable first one.
  sync2 #(.W(3)) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .d({bus_idle_pin, bus_kstate_pin, bus_reset_pin}),
    .q({idle_s, kstate_s, busrst_s})
  );

  // Idle timer restarts on any bus activity, so only unbroken idle fires.
  // At the default clock the span is 120000 cycles, hence the 24-bit counter.
  hold_timer #(.LIMIT(IDLE_CYCLES), .W(24)) u_idle (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .level(idle_s),
    .fire(idle_fire)
  );

  // Bus reset must hold 2.5 us; the timer re-arms only once the level drops.
  hold_timer #(.LIMIT(`BUSRST_CYCLES), .W(8)) u_busrst (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .level(busrst_s),
    .fire(busrst_fire)
  );

  // A K-state arms the wakeup; the delay counts from the clock restart.
  // A resume that outlasts the delay still fires only once per clock restart.
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_arm_reg <= 1'b0;
    end else if (ce) begin
      if (kstate_s) begin
        wake_arm_reg <= 1'b1;
      end else if (wakeup_fire) begin
        wake_arm_reg <= 1'b0;
      end
    end
  end

  hold_timer #(.LIMIT(`WAKEUP_CYCLES), .W(8)) u_wakeup (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .level(wake_arm_reg & clocks_restarted),
    .fire(wakeup_fire)
  );

  // -------------------------------------------------------------------------
  // Write channel
  // -------------------------------------------------------------------------
  // Address and data are taken in either order; the response follows both.
  // A write completes only while no response is outstanding.
  assign wr_fire = aw_have_reg && w_have_reg && (wr_state_reg == usb_event_pkg::WR_IDLE);

  // Each ready is a one-cycle pulse; the slot flag blocks a second take.
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 8'h00;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (ce) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
      end else begin
        if (s_axi_awvalid && !aw_have_reg && !s_axi_awready) begin
          s_axi_awready <= 1'b1;
          aw_have_reg <= 1'b1;
          awaddr_reg <= s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_reg && !s_axi_wready) begin
          s_axi_wready <= 1'b1;
          w_have_reg <= 1'b1;
          // Only the low byte lane carries register bits.
          wdata_reg <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
        end
      end
    end
  end

  // Response state: OKAY for mapped words, SLVERR for unmapped ones.
  // The response stands until bready, and no new write completes meanwhile.
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_state_reg <= usb_event_pkg::WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (ce) begin
      case (wr_state_reg)
        usb_event_pkg::WR_IDLE: begin
          if (wr_fire) begin
            wr_state_reg <= usb_event_pkg::WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_reg <= `XFER_STATUS_OFS && awaddr_reg[1:0] == 2'b00)
                           ? 2'b00 : 2'b10;
          end
        end
        usb_event_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_reg <= usb_event_pkg::WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state_reg <= usb_event_pkg::WR_IDLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Event and fault registers
  // -------------------------------------------------------------------------
  // Clear masks from one-writes; bit 6 is never implemented.
  assign ev_clear = (wr_fire && awaddr_reg == `EV_FLAGS_OFS) ? wdata_reg : 8'h00;
  assign fault_clear = (wr_fire && awaddr_reg == `FAULT_STATUS_OFS) ? wdata_reg : 8'h00;
  assign fault_any = |(fault_status_register_reg & fault_enables_reg);

  // Set sources gathered by bit position.
  always_comb begin
    set_vec = 8'h00;
    set_vec[`EV_BIT_STALL] = stall_sent;
    set_vec[`EV_BIT_WAKEUP] = wakeup_fire;
    set_vec[`EV_BIT_IDLE] = idle_fire;
    set_vec[`EV_BIT_XFER] = xfer_done;
    set_vec[`EV_BIT_SOF] = sof_token;
    set_vec[`EV_BIT_FAULT] = fault_any;
    set_vec[`EV_BIT_BUSRST] = busrst_fire;
  end

  // Sticky flags: a set in the clearing cycle wins so no event is lost.
  // Bit 6 is masked here as well, so no path can ever set it.
  always_ff @(posedge clk) begin
    if (rst) begin
      usb_event_flags_reg <= `EV_FLAGS_RST;
    end else if (ce) begin
      usb_event_flags_reg <= ((usb_event_flags_reg & ~ev_clear) | set_vec)
                             & `EV_IMPL_MASK;
    end
  end

  // Fault status bits are sticky and cleared by one-writes as well.
  // The fault flag follows them each cycle and re-sets while an enabled one stays pending.
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_status_register_reg <= `FAULT_RST;
    end else if (ce) begin
      fault_status_register_reg <= ((fault_status_register_reg & ~fault_clear) | fault_events)
                                   & `FAULT_IMPL_MASK;
    end
  end

  // Enable registers share bit positions with the flags they gate.
  // Writes land at the wr_fire edge, the same edge that raises bvalid.
  always_ff @(posedge clk) begin
    if (rst) begin
      usb_event_enables_reg <= `EV_ENABLES_RST;
      fault_enables_reg <= `FAULT_RST;
    end else if (ce && wr_fire) begin
      if (awaddr_reg == `EV_ENABLES_OFS) begin
        usb_event_enables_reg <= wdata_reg & `EV_IMPL_MASK;
      end
      if (awaddr_reg == `FAULT_ENABLES_OFS) begin
        fault_enables_reg <= wdata_reg & `FAULT_IMPL_MASK;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Transfer status
  // -------------------------------------------------------------------------
  // Clearing the transaction-done flag retires the shown status word.
  always_ff @(posedge clk) begin
    if (rst) begin
      xfer_status_reg <= 8'h00;
      xfer_queue_pop <= 1'b0;
    end else if (ce) begin
      xfer_queue_pop <= 1'b0;
      if (ev_clear[`EV_BIT_XFER]) begin
        // A completion in the clearing cycle wins, so its status word is not lost.
        xfer_status_reg <= (xfer_queue_valid || xfer_done) ? xfer_status_in : 8'h00;
        xfer_queue_pop <= xfer_queue_valid;
      end else if (xfer_done) begin
        xfer_status_reg <= xfer_status_in;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Interrupt request
  // -------------------------------------------------------------------------
  // Registered so the output comes straight from a flip-flop.
  // The request therefore trails its flag by one cycle, traded for a clean line.
  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(usb_event_flags_reg & usb_event_enables_reg);
    end
  end

  // -------------------------------------------------------------------------
  // Read channel
  // -------------------------------------------------------------------------
  // One read at a time. The address is acknowledged first and the data follow
  // one edge later, so rvalid never rises before the address handshake is done.
  // The master holds araddr until that handshake, so no copy is kept here.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (ce) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (s_axi_arready) begin
        // The address handshake completes at this edge; araddr is still held.
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `EV_FLAGS_OFS: s_axi_rdata <= {24'h00_0000, usb_event_flags_reg};
          `EV_ENABLES_OFS: s_axi_rdata <= {24'h00_0000, usb_event_enables_reg};
          `FAULT_STATUS_OFS: s_axi_rdata <= {24'h00_0000, fault_status_register_reg};
          `FAULT_ENABLES_OFS: s_axi_rdata <= {24'h00_0000, fault_enables_reg};
          `XFER_STATUS_OFS: s_axi_rdata <= {24'h00_0000, xfer_status_reg};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_arvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule : usb_event_interrupt_unit

/* usb_event_sva.sv */
// Port-level assertions for the USB event interrupt unit.
`timescale 1ns/100ps
`include "usb_event_cfg.svh"
module usb_event_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic xfer_queue_valid,
  input wire logic xfer_queue_pop,
  input wire logic irq
);
  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  // One clock domain, so every check shares the same clock and reset.
  default clocking cb @(posedge clk); endclocking
  // A frozen clock enable holds every state, so checks pause with it.
  default disable iff (rst || !ce);

  // Address of the read being answered; the transfer status word may use bit 6.
  logic [11:0] rd_addr_reg;
  always_ff @(posedge clk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_reg <= s_axi_araddr;
    end
  end

  hi_bits_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  bit_six_a: assert property (s_axi_rvalid && rd_addr_reg < `XFER_STATUS_OFS
    |-> !s_axi_rdata[6])
    else $error("unused bit six read as one");
  reset_quiet_a: assert property ($fell(rst) |-> !irq [*2])
    else $error("interrupt request high after reset");
  irq_clear_a: assert property ($fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("interrupt request fell without a register write");
  pop_once_a: assert property (xfer_queue_pop |=> !xfer_queue_pop)
    else $error("queue pop longer than one cycle");
  pop_cause_a: assert property (xfer_queue_pop |-> $past(xfer_queue_valid))
    else $error("queue pop with no waiting entry");
  write_resp_a: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid)
    else $error("write response missing after both channels taken");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed before handshake");
  err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 0)
    else $error("refused read returned nonzero data");
  // Main scenarios that must be reached.
  cover property (irq [*3]);
  cover property (xfer_queue_pop);
  cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule : usb_event_sva

bind usb_event_interrupt_unit usb_event_sva u_sva (.*);

/* usb_host_model.sv */
// Behavioural model of the bus lines and engine strobes feeding the event unit.
`timescale 1ns/100ps
module usb_host_model (
  input wire logic clk,
  input wire logic xfer_queue_pop,
  output logic stall_sent = 1'b0,
  output logic xfer_done = 1'b0,
  output logic sof_token = 1'b0,
  output logic [7:0] fault_events = 8'h00,
  output logic clocks_restarted = 1'b0,
  output logic [7:0] xfer_status_in = 8'h00,
  output logic xfer_queue_valid = 1'b0,
  output logic bus_idle_pin = 1'b0,
  output logic bus_kstate_pin = 1'b0,
  output logic bus_reset_pin = 1'b0
);
  // ---------------------------------------------------------------------------
  // Behaviour
  // ---------------------------------------------------------------------------
  // A waiting status entry is gone once the unit has taken it.
  always @(posedge clk) begin
    if (xfer_queue_pop) begin
      xfer_queue_valid <= 1'b0;
    end
  end

  // One-cycle event strobe; a held level would re-set the flag every cycle.
  task automatic pulse(input int b);
    @(posedge clk);
    stall_sent <= (b == 7);
    xfer_done <= (b == 3);
    sof_token <= (b == 2);
    fault_events <= {7'h00, b == 1};
    @(posedge clk);
    stall_sent <= 1'b0;
    xfer_done <= 1'b0;
    sof_token <= 1'b0;
    fault_events <= 8'h00;
  endtask : pulse

  // Line levels: 0 bus reset, 4 idle, 5 K-state, other values the clock restart.
  task automatic pin(input int w, input logic v);
    @(posedge clk);
    case (w)
      0: bus_reset_pin <= v;
      4: bus_idle_pin <= v;
      5: bus_kstate_pin <= v;
      default: clocks_restarted <= v;
    endcase
  endtask : pin

  // Next status word and whether a queued entry waits behind it.
  task automatic load(input logic [7:0] s, input logic q);
    @(posedge clk);
    xfer_status_in <= s;
    xfer_queue_valid <= q;
  endtask : load
endmodule : usb_host_model

/* tb.sv */
// Self-checking bench for the USB event interrupt unit.
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1;
  logic s_axi_rready = 1'b1;
  logic ce = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic stall_sent, xfer_done, sof_token, clocks_restarted, xfer_queue_valid, xfer_queue_pop;
  logic bus_idle_pin, bus_kstate_pin, bus_reset_pin;
  logic [7:0] fault_events, xfer_status_in;
  int n_errors = 0;
  int compares = 0;
  int ev [4] = '{7, 3, 2, 1};

  // ---------------------------------------------------------------------------
  // Harness
  // ---------------------------------------------------------------------------
  // Free-running 40 MHz clock.
  initial begin
    forever #12.5 clk = ~clk;
  end

  // Short idle limit keeps the run brief; expectations use the same figure.
  usb_event_interrupt_unit #(.IDLE_CYCLES(50)) u_dut (.s_axi_wstrb(4'h1), .*);
  usb_host_model host (.*);

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic irq_is(input logic e);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask : irq_is

  // Address and data go out together; each is dropped once its ready is seen.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 200);
    chk("bvalid", 32'h1, {31'h0, s_axi_bvalid});
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr

  // The extra edge at the end keeps back-to-back reads legal.
  // A nonzero lag keeps rready low for that many edges after rvalid is seen.
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er,
                    input int lag = 0);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 200);
    if (lag > 0) begin
      cyc(lag);
      s_axi_rready <= 1'b1;
      @(posedge clk);
    end
    chk("rvalid", 32'h1, {31'h0, s_axi_rvalid});
    chk("rdata", e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    @(posedge clk);
  endtask : rd

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Cuts a hang short; the tests need some 830 cycles.
  initial begin
    cyc(8000);
    n_errors++;
    tally_and_finish();
  end

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  // Register map, each event path, masking, pin timers and the status queue.
  initial begin
    cyc(4);
    rst <= 1'b0;
    cyc(2);
    rd(12'h000, 32'h0, 2'b00);
    rd(12'h004, 32'h0, 2'b00);
    rd(12'h020, 32'h0, 2'b10);
    wr(12'h020, 32'hFF, 2'b10);
    wr(12'h004, 32'hFF, 2'b00);
    rd(12'h004, 32'hBF, 2'b00, 2);
    wr(12'h000, 32'h40, 2'b00);
    rd(12'h000, 32'h0, 2'b00);
    wr(12'h00C, 32'h1, 2'b00);
    $display("map test done");
    for (int i = 0; i < 4; i++) begin
      host.pulse(ev[i]);
      cyc(3);
      irq_is(1'b1);
      rd(12'h000, 32'h1 << ev[i], 2'b00);
      wr(12'h000, 32'h0, 2'b00);
      rd(12'h000, 32'h1 << ev[i], 2'b00);
      if (ev[i] == 1) begin
        rd(12'h008, 32'h1, 2'b00);
        wr(12'h008, 32'h1, 2'b00);
      end
      wr(12'h000, 32'h1 << ev[i], 2'b00);
      rd(12'h000, 32'h0, 2'b00);
      irq_is(1'b0);
    end
    $display("event test done");
    wr(12'h004, 32'h0, 2'b00);
    host.pulse(7);
    cyc(3);
    irq_is(1'b0);
    wr(12'h004, 32'h80, 2'b00);
    cyc(2);
    irq_is(1'b1);
    wr(12'h000, 32'h80, 2'b00);
    $display("mask test done");
    host.pin(0, 1'b1);
    cyc(50);
    rd(12'h000, 32'h0, 2'b00);
    cyc(60);
    rd(12'h000, 32'h1, 2'b00);
    // Firmware services the bus reset; address and endpoint set-up live elsewhere.
    wr(12'h000, 32'h1, 2'b00);
    cyc(150);
    rd(12'h000, 32'h0, 2'b00);
    host.pin(0, 1'b0);
    cyc(5);
    host.pin(0, 1'b1);
    cyc(110);
    rd(12'h000, 32'h1, 2'b00);
    host.pin(0, 1'b0);
    wr(12'h000, 32'h1, 2'b00);
    $display("bus reset test done");
    host.pin(4, 1'b1);
    cyc(30);
    host.pin(4, 1'b0);
    cyc(3);
    host.pin(4, 1'b1);
    cyc(30);
    rd(12'h000, 32'h0, 2'b00);
    cyc(30);
    rd(12'h000, 32'h10, 2'b00);
    host.pin(4, 1'b0);
    wr(12'h000, 32'h10, 2'b00);
    wr(12'h004, 32'h20, 2'b00);
    host.pin(5, 1'b1);
    cyc(5);
    host.pin(5, 1'b0);
    host.pin(6, 1'b1);
    cyc(80);
    irq_is(1'b0);
    cyc(30);
    irq_is(1'b1);
    rd(12'h000, 32'h20, 2'b00);
    host.pin(6, 1'b0);
    wr(12'h000, 32'h20, 2'b00);
    $display("idle and wakeup test done");
    host.load(8'h1A, 1'b0);
    host.pulse(3);
    cyc(2);
    rd(12'h010, 32'h1A, 2'b00);
    host.load(8'h21, 1'b1);
    wr(12'h000, 32'h08, 2'b00);
    rd(12'h010, 32'h21, 2'b00);
    host.pulse(3);
    cyc(2);
    wr(12'h000, 32'h08, 2'b00);
    rd(12'h010, 32'h0, 2'b00);
    $display("status queue test done");
    // With the clock enable low a strobe must leave no trace in the flags.
    ce <= 1'b0;
    host.pulse(7);
    cyc(1);
    ce <= 1'b1;
    rd(12'h000, 32'h0, 2'b00);
    irq_is(1'b0);
    $display("clock enable test done");
    tally_and_finish();
  end
endmodule : tb
